// file: pkg/ssc_pkg.sv
// Shared constants and types for the serial status and frame control block
package ssc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_FRAME = 8'h08;
  localparam logic [7:0] OFS_ENABLE = 8'h0C;
  // Status bit positions
  localparam int ST_TX_EMPTY = 7;
  localparam int ST_TX_DONE = 6;
  localparam int ST_RX_READY = 5;
  localparam int ST_QUIET = 4;
  localparam int ST_OVERRUN = 3;
  localparam int ST_NOISE = 2;
  localparam int ST_FRAMING = 1;
  localparam int ST_PARITY = 0;
  // Frame control bit positions
  localparam int FC_RX9 = 7;
  localparam int FC_TX9 = 6;
  localparam int FC_LPD = 5;
  localparam int FC_NINE = 4;
  localparam int FC_WAKE = 3;
  localparam int FC_PAR_EN = 2;
  localparam int FC_PAR_ODD = 1;
  localparam int FC_PAR_IE = 0;
  // Enable control bit positions
  localparam int EC_TX_IE = 7;
  localparam int EC_TXD_IE = 6;
  localparam int EC_RX_IE = 5;
  localparam int EC_QL_IE = 4;
  localparam int EC_TX_EN = 3;
  localparam int EC_RX_EN = 2;
  localparam int EC_MUTE = 1;
  // Values after reset and masks
  localparam logic [7:0] STATUS_RST = 8'hC0;
  localparam logic [7:0] FRAME_RST = 8'h00;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [7:0] ENABLE_WMASK = 8'hFE;
  localparam logic [7:0] CLR_ON_WRITE = 8'hC1;
  localparam logic [7:0] CLR_ON_READ = 8'h3F;
  // Oversampling and line timing counts
  localparam int OVS = 16;
  localparam logic [3:0] SMP_FIRST = 4'h7;
  localparam logic [3:0] SMP_LAST = 4'h9;
  localparam logic [7:0] QUIET_TICKS_8 = 8'hA0;
  localparam logic [7:0] QUIET_TICKS_9 = 8'hB0;
  localparam int DIV_DEFAULT = 22;
  // Line engine state
  typedef enum logic {LN_IDLE = 1'b0, LN_BUSY = 1'b1} ssc_line_t;
  // Frame format snapshot
  typedef struct packed {
    logic nine;
    logic par_en;
    logic par_odd;
  } ssc_fmt_t;
  // Received word with its error marks
  typedef struct packed {
    logic [8:0] data;
    logic noise;
    logic framing;
    logic par_err;
  } ssc_rx_word_t;
endpackage

// file: rtl/ssc_rx.sv
// Receive sampler: 16x oversampling, majority vote, noise, framing and parity
`timescale 1ns/1ps
module ssc_rx import ssc_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Timing and control
  input wire logic tick,
  input wire logic enable,
  input wire ssc_fmt_t fmt,
  // Serial line
  input wire logic rxd,
  // Result
  output logic word_valid,
  output ssc_rx_word_t word,
  output logic idle_seen,
  output logic busy
);
  ssc_line_t state_q;
  ssc_fmt_t fmt_q;
  logic [3:0] sub_q;
  logic [3:0] bit_q;
  logic [2:0] smp_q;
  logic [9:0] shift_q;
  logic noise_q;
  logic valid_q;
  logic idle_q;
  logic [7:0] quiet_q;
  ssc_rx_word_t word_q;

  // Majority of samples 8, 9 and 10 and their disagreement
  wire maj = (smp_q[0] & smp_q[1]) | (smp_q[0] & smp_q[2]) | (smp_q[1] & smp_q[2]);
  wire split = ~(&smp_q) & (|smp_q);
  wire in_sample = (sub_q >= SMP_FIRST) && (sub_q <= SMP_LAST);
  wire [3:0] last = fmt_q.nine ? 4'hA : 4'h9;
  wire [9:0] nxt = {maj, shift_q[9:1]};
  wire [8:0] data = fmt_q.nine ? nxt[8:0] : {1'b0, nxt[8:1]};
  wire par_bad = fmt_q.par_en & ((^data) ^ fmt_q.par_odd);
  wire [7:0] quiet_len = fmt.nine ? QUIET_TICKS_9 : QUIET_TICKS_8;

  // Start search, bit sampling and word completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= LN_IDLE;
      fmt_q <= '0;
      sub_q <= 4'h0;
      bit_q <= 4'h0;
      smp_q <= 3'h0;
      shift_q <= 10'h000;
      noise_q <= 1'b0;
      valid_q <= 1'b0;
      idle_q <= 1'b0;
      quiet_q <= 8'h00;
      word_q <= '0;
    end else begin
      valid_q <= 1'b0;
      idle_q <= 1'b0;
      if (!enable) begin
        state_q <= LN_IDLE;
        quiet_q <= 8'h00;
      end else if (tick) begin
        if (!rxd) quiet_q <= 8'h00;
        else if (quiet_q != 8'hFF) quiet_q <= quiet_q + 8'h01;
        idle_q <= rxd && (quiet_q == quiet_len - 8'h01);
        if (state_q == LN_IDLE) begin
          if (!rxd) begin
            state_q <= LN_BUSY;
            sub_q <= 4'h1;
            bit_q <= 4'h0;
            noise_q <= 1'b0;
            fmt_q <= fmt;
          end
        end else begin
          sub_q <= sub_q + 4'h1;
          if (in_sample) smp_q <= {rxd, smp_q[2:1]};
          if (sub_q == 4'(OVS - 1)) begin
            bit_q <= bit_q + 4'h1;
            shift_q <= nxt;
            noise_q <= noise_q | split;
            if (bit_q == 4'h0 && maj) begin
              state_q <= LN_IDLE;
            end else if (bit_q == last) begin
              state_q <= LN_IDLE;
              valid_q <= 1'b1;
              word_q <= '{data: data, noise: noise_q | split, framing: ~maj, par_err: par_bad};
            end
          end
        end
      end
    end
  end

  assign word_valid = valid_q;
  assign word = word_q;
  assign idle_seen = idle_q;
  assign busy = state_q == LN_BUSY;
endmodule

// file: rtl/ssc_status_ctrl.sv
// Serial interface status flags, frame control, APB registers and interrupt request
`timescale 1ns/1ps
// What this block does
// - In Halt, stop transmit and receive and freeze flag and control registers; bus reads still answer, requests drop.
// - Enabled serial events wake the chip from Wait, never from Halt.
// - One shared request; each event needs its enable and a cleared global mask.
// - Request ORs tx empty, tx done, rx ready, overrun, quiet line, parity error.
// - Tx empty sets on holding-to-shifter move; status access then data write clears.
// - Holding data moves to the shifter only once tx empty was cleared.
// - Tx done sets after a data frame ends; status access then data write clears.
// - Rx ready sets when a word lands in holding; status then data read clears.
// - Quiet flag sets on idle line; cleared likewise; rearmed only by rx ready.
// - Overrun when a word completes while rx ready; holding kept; cleared likewise.
// - Noise flag sets with a noisy frame, no own interrupt; status then read clears.
// - Framing flag on bad stop, no own interrupt; overrun wins over framing.
// - Parity error flag on failed check, interrupt with its enable; cleared by sequence.
// - Status register is read-only and resets to C0h.
// - Nine-bit words put received bit 9 in control bit 7, send control bit 6.
// - Low-power bit stops prescaler and outputs after the current byte.
// - Word-length bit selects 8 or 9 data bits; software keeps it stable mid-frame.
// - Wake bit chooses muted receiver wake by idle line or address mark.
// - Parity enable puts parity in the top data bit and checks it, from next byte.
// - Parity select chooses even or odd, effective from the next byte.
// - Frame control bits 6 to 0 reset to zero.
// - While muted, no reception flag sets and receive interrupts are blocked.
// - Address mark word clears mute and sets rx ready, received normally.
module ssc_status_ctrl import ssc_pkg::*; #(
  parameter int DIV = DIV_DEFAULT
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Chip power and core state
  input wire logic halt_mode,
  input wire logic wait_mode,
  input wire logic cond_code_irq_mask,
  output logic irq_req,
  output logic wake_req,
  // Serial line
  input wire logic rxd,
  output logic txd
);
  // Registers
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [7:0] status_set;
  logic [7:0] status_clr;
  logic [7:0] frame_q;
  logic [7:0] frame_d;
  logic [7:0] enable_q;
  logic [7:0] enable_d;
  logic [7:0] armed_q;
  logic [7:0] armed_d;
  logic [7:0] tx_hold_q;
  logic [7:0] rx_hold_q;
  logic quiet_allow_q;
  logic quiet_allow_d;
  logic [15:0] div_q;
  logic tick_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic irq_q;
  logic wake_q;
  // Engine signals
  logic tx_busy;
  logic tx_done;
  logic rx_busy;
  logic rx_valid;
  logic rx_idle;
  ssc_rx_word_t rx_word;
  ssc_fmt_t fmt;

  // Halt freezes flags, controls and engines, including software effects
  wire run = ~halt_mode;

  // APB phases
  wire setup = psel & ~penable;
  wire access = psel & penable & pready_q;
  wire wr_ok = access & pwrite & run;
  wire rd_ok = access & ~pwrite & run;

  // Address decode
  wire sel_status = paddr == OFS_STATUS;
  wire sel_data = paddr == OFS_DATA;
  wire sel_frame = paddr == OFS_FRAME;
  wire sel_enable = paddr == OFS_ENABLE;
  wire hit = sel_status | sel_data | sel_frame | sel_enable;

  // Read data selection, upper bits read as zero
  wire [7:0] rd_byte = sel_status ? status_q :
                       sel_data ? rx_hold_q :
                       sel_frame ? frame_q :
                       sel_enable ? enable_q : 8'h00;

  // Software access strobes
  wire status_rd = rd_ok & sel_status;
  wire data_wr = wr_ok & sel_data;
  wire data_rd = rd_ok & sel_data;
  wire frame_wr = wr_ok & sel_frame;
  wire enable_wr = wr_ok & sel_enable;

  // Control field views
  wire muted = enable_q[EC_MUTE];
  wire wake_addr_sel = frame_q[FC_WAKE];
  wire low_power = frame_q[FC_LPD];
  wire nine = frame_q[FC_NINE];
  wire par_en = frame_q[FC_PAR_EN];
  wire par_odd = frame_q[FC_PAR_ODD];

  // Current format handed to the receiver, latched per frame there
  assign fmt = '{nine: nine, par_en: par_en, par_odd: par_odd};

  // Prescaler stops at once in Halt; in low power only once both engines finish their byte
  wire tick_run = run & ~(low_power & ~tx_busy & ~rx_busy);
  wire div_wrap = div_q == 16'(DIV - 1);
  wire tick = tick_q & run;

  // Oversampling divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick_run & div_wrap;
      if (tick_run) div_q <= div_wrap ? 16'h0000 : div_q + 16'h0001;
    end
  end

  // Parity in the top data position, even or odd
  wire par7 = (^tx_hold_q[6:0]) ^ par_odd;
  wire par8 = (^tx_hold_q) ^ par_odd;
  wire [8:0] tx_plain = {frame_q[FC_TX9], tx_hold_q};
  wire [8:0] tx_par = nine ? {par8, tx_hold_q} : {1'b0, par7, tx_hold_q[6:0]};
  wire [8:0] tx_word = par_en ? tx_par : tx_plain;

  // Move holding to shifter only after software cleared tx empty
  wire tx_go = run & enable_q[EC_TX_EN] & ~status_q[ST_TX_EMPTY] & ~tx_busy
               & ~low_power;

  // Transmit shifter
  ssc_tx u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .load(tx_go),
    .load_data(tx_word),
    .nine(nine),
    .busy(tx_busy),
    .done(tx_done),
    .txd(txd)
  );

  // Receive sampler
  ssc_rx u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .enable(enable_q[EC_RX_EN]),
    .fmt(fmt),
    .rxd(rxd),
    .word_valid(rx_valid),
    .word(rx_word),
    .idle_seen(rx_idle),
    .busy(rx_busy)
  );

  // Top data bit, not the parity meaning, marks an address
  wire rx_msb = nine ? rx_word.data[8] : rx_word.data[7];
  wire addr_wake = run & rx_valid & muted & wake_addr_sel & rx_msb;
  wire idle_wake = run & rx_idle & muted & ~wake_addr_sel;
  wire hw_unmute = addr_wake | idle_wake;

  // Word acceptance while active or on address wake
  wire rx_accept = run & rx_valid & (~muted | addr_wake);
  wire rx_ovr = rx_accept & status_q[ST_RX_READY];
  wire rx_load = rx_accept & ~status_q[ST_RX_READY];
  wire quiet_set = run & rx_idle & ~muted & quiet_allow_q;

  // Hardware set terms per flag
  assign status_set[ST_TX_EMPTY] = tx_go;
  assign status_set[ST_TX_DONE] = run & tx_done;
  assign status_set[ST_RX_READY] = rx_load;
  assign status_set[ST_QUIET] = quiet_set;
  assign status_set[ST_OVERRUN] = rx_ovr;
  assign status_set[ST_NOISE] = rx_load & rx_word.noise;
  assign status_set[ST_FRAMING] = rx_load & rx_word.framing;
  assign status_set[ST_PARITY] = rx_load & rx_word.par_err;

  // Data access clears only flags armed by the last status read
  wire [7:0] clr_wr_mask = {8{data_wr}} & CLR_ON_WRITE;
  wire [7:0] clr_rd_mask = {8{data_rd}} & CLR_ON_READ;
  assign status_clr = (clr_wr_mask | clr_rd_mask) & armed_q;

  // A set arriving with its clear wins
  assign status_d = (status_q & ~status_clr) | status_set;

  // Arm on status read, disarm on any data access
  assign armed_d = status_rd ? status_q :
                   (data_wr | data_rd) ? 8'h00 : armed_q;

  // Quiet flag rearms only after rx ready sets again
  assign quiet_allow_d = rx_load ? 1'b1 : quiet_set ? 1'b0 : quiet_allow_q;

  // Frame control: bit 7 is written only by the receiver
  wire [6:0] frame_low = frame_wr ? pwdata[6:0] : frame_q[6:0];
  wire frame_r9 = (rx_load & nine) ? rx_word.data[8] : frame_q[FC_RX9];
  assign frame_d = {frame_r9, frame_low};

  // Enable control: hardware clears mute on a wake event
  wire [7:0] unmute_mask = ~(8'(hw_unmute) << EC_MUTE);
  assign enable_d = enable_wr ? (pwdata[7:0] & ENABLE_WMASK) : (enable_q & unmute_mask);

  // Flag and control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= STATUS_RST;
      frame_q <= FRAME_RST;
      enable_q <= ENABLE_RST;
      armed_q <= 8'h00;
      quiet_allow_q <= 1'b0;
    end else begin
      status_q <= status_d;
      frame_q <= frame_d;
      enable_q <= enable_d;
      armed_q <= armed_d;
      quiet_allow_q <= quiet_allow_d;
    end
  end

  // Holding registers; overrun keeps the held word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_hold_q <= 8'h00;
      rx_hold_q <= 8'h00;
    end else begin
      if (data_wr) tx_hold_q <= pwdata[7:0];
      if (rx_load) rx_hold_q <= rx_word.data[7:0];
    end
  end

  // APB answer: ready in the first access cycle, error on unmapped offsets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~hit;
      if (setup) prdata_q <= {24'h00_0000, rd_byte};
    end
  end

  // Receive interrupts are blocked while muted
  wire rx_irq_ok = ~muted;
  wire ev_tx_empty = status_q[ST_TX_EMPTY] & enable_q[EC_TX_IE];
  wire ev_tx_done = status_q[ST_TX_DONE] & enable_q[EC_TXD_IE];
  wire ev_rx = (status_q[ST_RX_READY] | status_q[ST_OVERRUN]) & enable_q[EC_RX_IE] & rx_irq_ok;
  wire ev_quiet = status_q[ST_QUIET] & enable_q[EC_QL_IE] & rx_irq_ok;
  wire ev_parity = status_q[ST_PARITY] & frame_q[FC_PAR_IE] & rx_irq_ok;
  wire irq_event = ev_tx_empty | ev_tx_done | ev_rx | ev_quiet | ev_parity;

  // Shared request and Wait wake-up, both silent in Halt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      irq_q <= run & irq_event & ~cond_code_irq_mask;
      wake_q <= run & irq_event & wait_mode;
    end
  end

  // Outputs straight from flip-flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq_req = irq_q;
  assign wake_req = wake_q;
endmodule

// file: rtl/ssc_tx.sv
// Transmit shifter: start bit, eight or nine data bits, stop bit
`timescale 1ns/1ps
module ssc_tx import ssc_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Oversampling tick
  input wire logic tick,
  // Load side
  input wire logic load,
  input wire logic [8:0] load_data,
  input wire logic nine,
  output logic busy,
  output logic done,
  // Serial line
  output logic txd
);
  ssc_line_t state_q;
  logic [10:0] shift_q;
  logic [3:0] bits_q;
  logic [3:0] sub_q;
  logic done_q;

  // Bit boundary and last bit
  wire bit_end = (state_q == LN_BUSY) && tick && (sub_q == 4'(OVS - 1));
  wire last_bit = bits_q == 4'h1;

  // Frame is built at load, so format changes wait for the next byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= LN_IDLE;
      shift_q <= 11'h7FF;
      bits_q <= 4'h0;
      sub_q <= 4'h0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (load && state_q == LN_IDLE) begin
        state_q <= LN_BUSY;
        shift_q <= nine ? {1'b1, load_data, 1'b0} : {2'b11, load_data[7:0], 1'b0};
        bits_q <= nine ? 4'hB : 4'hA;
        sub_q <= 4'h0;
      end else if (state_q == LN_BUSY && tick) begin
        sub_q <= sub_q + 4'h1;
        if (bit_end) begin
          shift_q <= {1'b1, shift_q[10:1]};
          bits_q <= bits_q - 4'h1;
          if (last_bit) begin
            state_q <= LN_IDLE;
            done_q <= 1'b1;
          end
        end
      end
    end
  end

  // Line idles high because ones are shifted in behind the frame
  assign txd = shift_q[0];
  assign busy = state_q == LN_BUSY;
  assign done = done_q;
endmodule

// file: tb/ssc_far_end.sv
// Remote serial station on the far side of the line
`timescale 1ns/1ps
module ssc_far_end #(
  parameter int BIT = 32
) (
  // Clock and format
  input wire logic clk,
  input wire logic nine,
  // Serial lines
  input wire logic txd,
  output logic rxd,
  // Decoded word
  output logic got,
  output logic [8:0] got_word
);
  logic [9:0] sh;
  // Line idles high
  initial begin
    rxd = 1'b1;
    got = 1'b0;
    got_word = 9'h000;
  end
  // Start, data LSB first, stop, one idle bit; format held for the frame
  task automatic send(input logic [8:0] w, input logic stop);
    logic [11:0] f;
    f = nine ? {1'b1, stop, w, 1'b0} : {2'b11, stop, w[7:0], 1'b0};
    for (int i = 0; i < 11 + nine; i++) begin
      rxd <= f[i];
      repeat (BIT) @(posedge clk);
    end
  endtask
  // Decode frames from the block in mid bit
  always begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 9 + nine; i++) begin
      repeat (BIT) @(posedge clk);
      sh = {txd, sh[9:1]};
    end
    got_word <= nine ? sh[8:0] : {1'b0, sh[8:1]};
    got <= 1'b1;
    @(posedge clk);
    got <= 1'b0;
  end
endmodule

// file: tb/ssc_status_ctrl_sva.sv
// Port assertions for the serial status and frame control block
`timescale 1ns/1ps
module ssc_status_ctrl_sva import ssc_pkg::*; #(
  parameter int DIV = DIV_DEFAULT
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Core state and requests
  input wire logic halt_mode,
  input wire logic wait_mode,
  input wire logic cond_code_irq_mask,
  input wire logic irq_req,
  input wire logic wake_req,
  // Serial line
  input wire logic txd
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup cycle and address decode
  wire logic setup = psel && !penable;
  wire logic mapped = paddr inside {OFS_STATUS, OFS_DATA, OFS_FRAME, OFS_ENABLE};
  // Bus answers
  property p_zero_wait; setup |=> pready; endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("setup not answered");
  property p_err_map; setup && !mapped && !pwrite |=> pslverr && prdata == 32'h0; endproperty
  a_err_map: assert property (p_err_map) else $error("unmapped read answer");
  property p_ok_map; setup && mapped |=> !pslverr; endproperty
  a_ok_map: assert property (p_ok_map) else $error("error on mapped place");
  property p_hi_zero; pready |-> prdata[31:8] == 24'h0; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
  // Request, mask, wait and halt
  property p_mask; cond_code_irq_mask |=> !irq_req; endproperty
  a_mask: assert property (p_mask) else $error("request while masked");
  property p_halt; halt_mode |=> !irq_req && !wake_req; endproperty
  a_halt: assert property (p_halt) else $error("request in halt");
  property p_no_wait; !wait_mode |=> !wake_req; endproperty
  a_no_wait: assert property (p_no_wait) else $error("wake outside wait");
  property p_same; wait_mode && !cond_code_irq_mask |=> irq_req == wake_req; endproperty
  a_same: assert property (p_same) else $error("wake and request differ");
  property p_freeze; halt_mode |=> $stable(txd); endproperty
  a_freeze: assert property (p_freeze) else $error("line moved in halt");
  // Main scenarios
  c_irq: cover property (irq_req);
  c_wake: cover property (wake_req);
  c_err: cover property (pslverr);
endmodule

// file: tb/test_ssc_status_ctrl.sv
// Self-checking bench for the serial status and frame control block
`timescale 1ns/1ps
module test_ssc_status_ctrl;
  import ssc_pkg::*;
  localparam int DV = 2;
  localparam int BT = 16 * DV;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic halt_mode = 1'b0, wait_mode = 1'b0, cond_code_irq_mask = 1'b0, nine = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq_req, wake_req, rxd, txd, got;
  logic [8:0] got_word;
  logic [31:0] rd_q[$];
  logic [8:0] tx_q[$];
  logic [31:0] rng = 32'h0000000D;
  logic [7:0] fmt_tab[5] = '{8'h00, 8'h04, 8'h06, 8'h50, 8'h56};
  int error_cnt = 0, num_checks = 0, cyc = 0;
  // Clock
  always #12.5 pclk = ~pclk;
  ssc_status_ctrl #(.DIV(DV)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .halt_mode(halt_mode), .wait_mode(wait_mode),
    .cond_code_irq_mask(cond_code_irq_mask), .irq_req(irq_req), .wake_req(wake_req),
    .rxd(rxd), .txd(txd));
  ssc_far_end #(.BIT(BT)) i_far (.clk(pclk), .nine(nine), .txd(txd), .rxd(rxd), .got(got),
    .got_word(got_word));
  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Random source
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Word expected on the line for a frame setting
  function automatic logic [8:0] exp_tx(input logic [7:0] fc, input logic [7:0] d);
    logic [8:0] w;
    w = {fc[FC_TX9] & fc[FC_NINE], d};
    if (fc[FC_PAR_EN] && fc[FC_NINE]) w[8] = ^d ^ fc[FC_PAR_ODD];
    if (fc[FC_PAR_EN] && !fc[FC_NINE]) w[7] = ^d[6:0] ^ fc[FC_PAR_ODD];
    return w;
  endfunction
  // One APB transfer held until pready, then an idle cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Read with its expectation noted first
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back({24'h0, e});
    apb(1'b0, a, 8'h00);
  endtask
  // Until the far end has the word, then one bit for the done flag
  task automatic wait_tx();
    for (int n = 0; n < 20 * BT && tx_q.size() > 0; n++) @(posedge pclk);
    repeat (BT) @(posedge pclk);
  endtask
  // Results against the oldest note; cycle ceiling
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && rd_q.size() > 0) begin
      check("prdata", prdata, rd_q.pop_front());
    end
    if (got && tx_q.size() > 0) begin
      check("tx word", {23'h0, got_word}, {23'h0, tx_q.pop_front()});
    end
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFS_STATUS, 8'hC0);
    rd(OFS_FRAME, 8'h00);
    rd(OFS_ENABLE, 8'h00);
    apb(1'b1, OFS_STATUS, 8'h3F);
    rd(OFS_STATUS, 8'hC0);
    rd(8'h10, 8'h00);
    repeat (3) begin
      rng = xs(rng);
      apb(1'b1, OFS_FRAME, rng[7:0] & 8'hDF);
      rd(OFS_FRAME, rng[7:0] & 8'h5F);
    end
    apb(1'b1, OFS_FRAME, 8'h00);
    for (int i = 2; i >= 0; i--) begin
      apb(1'b1, OFS_ENABLE, 8'h80 >> i);
      repeat (2) @(posedge pclk);
      check("irq", {31'h0, irq_req}, {31'h0, i < 2});
    end
    cond_code_irq_mask <= 1'b1;
    repeat (2) @(posedge pclk);
    check("irq masked", {31'h0, irq_req}, 32'h0);
    wait_mode <= 1'b1;
    repeat (2) @(posedge pclk);
    check("wake", {31'h0, wake_req}, 32'h1);
    halt_mode <= 1'b1;
    repeat (2) @(posedge pclk);
    check("wake in halt", {31'h0, wake_req}, 32'h0);
    apb(1'b1, OFS_FRAME, 8'h0E);
    rd(OFS_FRAME, 8'h00);
    halt_mode <= 1'b0;
    wait_mode <= 1'b0;
    cond_code_irq_mask <= 1'b0;
    // Transmit: clear sequence, held word, then five frame formats
    apb(1'b1, OFS_ENABLE, 8'h00);
    rd(OFS_STATUS, 8'hC0);
    apb(1'b1, OFS_DATA, 8'hA5);
    rd(OFS_STATUS, 8'h00);
    tx_q.push_back(9'h0A5);
    apb(1'b1, OFS_ENABLE, 8'h08);
    wait_tx();
    foreach (fmt_tab[k]) begin
      rng = xs(rng);
      nine <= fmt_tab[k][FC_NINE];
      apb(1'b1, OFS_FRAME, fmt_tab[k]);
      rd(OFS_STATUS, 8'hC0);
      tx_q.push_back(exp_tx(fmt_tab[k], rng[7:0]));
      apb(1'b1, OFS_DATA, rng[7:0]);
      wait_tx();
    end
    // Receive: ready, quiet line, overrun, framing, parity, mute
    nine <= 1'b0;
    apb(1'b1, OFS_FRAME, 8'h00);
    apb(1'b1, OFS_ENABLE, 8'h2C);
    i_far.send(9'h05A, 1'b1);
    check("irq rx", {31'h0, irq_req}, 32'h1);
    rd(OFS_STATUS, 8'hE0);
    rd(OFS_DATA, 8'h5A);
    repeat (12 * BT) @(posedge pclk);
    rd(OFS_STATUS, 8'hD0);
    rd(OFS_DATA, 8'h5A);
    repeat (12 * BT) @(posedge pclk);
    rd(OFS_STATUS, 8'hC0);
    i_far.send(9'h011, 1'b1);
    i_far.send(9'h022, 1'b1);
    rd(OFS_STATUS, 8'hE8);
    rd(OFS_DATA, 8'h11);
    i_far.send(9'h033, 1'b0);
    rd(OFS_STATUS, 8'hE2);
    rd(OFS_DATA, 8'h33);
    apb(1'b1, OFS_FRAME, 8'h05);
    i_far.send(9'h001, 1'b1);
    rd(OFS_STATUS, 8'hE1);
    rd(OFS_DATA, 8'h01);
    apb(1'b1, OFS_FRAME, 8'h08);
    apb(1'b1, OFS_ENABLE, 8'h2E);
    i_far.send(9'h012, 1'b1);
    rd(OFS_STATUS, 8'hC0);
    i_far.send(9'h092, 1'b1);
    rd(OFS_ENABLE, 8'h2C);
    rd(OFS_STATUS, 8'hE0);
    rd(OFS_DATA, 8'h92);
    // Nine-bit receive, idle-line wake, low-power hold of the transmitter
    nine <= 1'b1;
    apb(1'b1, OFS_FRAME, 8'h10);
    i_far.send(9'h1C3, 1'b1);
    rd(OFS_FRAME, 8'h90);
    rd(OFS_STATUS, 8'hE0);
    rd(OFS_DATA, 8'hC3);
    apb(1'b1, OFS_ENABLE, 8'h2E);
    repeat (12 * BT) @(posedge pclk);
    rd(OFS_ENABLE, 8'h2C);
    rd(OFS_STATUS, 8'hC0);
    apb(1'b1, OFS_FRAME, 8'h20);
    rd(OFS_STATUS, 8'hC0);
    apb(1'b1, OFS_DATA, 8'h3C);
    repeat (BT) @(posedge pclk);
    rd(OFS_STATUS, 8'h00);
    nine <= 1'b0;
    tx_q.push_back(9'h03C);
    apb(1'b1, OFS_FRAME, 8'h00);
    wait_tx();
    check("pending", rd_q.size() + tx_q.size(), 32'h0);
    complete_run();
  end
endmodule
bind ssc_status_ctrl ssc_status_ctrl_sva #(.DIV(DIV)) i_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .halt_mode(halt_mode), .wait_mode(wait_mode),
  .cond_code_irq_mask(cond_code_irq_mask), .irq_req(irq_req), .wake_req(wake_req),
  .txd(txd));
